// file: hdl/pmfc_power_ctrl.v
/*
 * power manager and pin float test mode control.
 * assumes the core supplies ref_clk and nrst, board logic drives
 * reset_in_n and the float test strap, and the bus unit supplies
 * addr_data_bus output values and a bus hold acknowledge.
 */
// Summary of operation
// - the power manager has active, idle, powerdown and wake states and in active every unit is clocked outside reset.
// - in idle the execution and bus unit clocks stop low while peripheral clocks keep running.
// - in powerdown every internal clock stops low and the oscillator is disabled.
// - in powerdown every register keeps its contents so operation resumes unchanged.
// - in pin float test mode every output and bidirectional pin is high impedance.
// - pin float test mode is selected when the strap is low while reset input is active.
// - during reset the strap pin is weakly pulled high so an undriven strap selects normal mode.
// - every output pin has a defined state in bus hold, reset, idle and powerdown.
// - the address data pins float pin_float_test_mode bus hold is acknowledged.
// - the address data pins float during reset.
// - the address data pins keep their last driven value in powerdown.
// - the reset output stays asserted as long as the reset input is asserted.
// - on leaving powerdown the device waits for the wake delay timer pin before resuming.
`timescale 1ns/1ps
`default_nettype none
`include "pmfc_defines.vh"

module pmfc_power_ctrl (
    input wire ref_clk,
    input wire nrst,
    input wire reset_in_n,
    input wire [1:0] mode_req,
    input wire mode_req_valid,
    input wire wake_event,
    input wire float_test_strap_in,
    output reg float_test_strap_out,
    output reg float_test_strap_oe,
    output wire float_test_strap_pullup,
    input wire wake_delay_timer_pin_in,
    output reg wake_delay_timer_pin_out,
    output reg wake_delay_timer_pin_oe,
    input wire bus_hold_ack,
    input wire [15:0] bus_ad_value,
    input wire bus_ad_drive,
    input wire [15:0] addr_data_bus_in,
    output reg [15:0] addr_data_bus_out,
    output reg [15:0] addr_data_bus_oe,
    output wire [15:0] bus_ad_sample,
    output reg reset_out,
    output reg reset_out_oe,
    output reg osc_enable,
    output wire exec_clk,
    output wire bus_clk,
    output wire periph_clk,
    output reg regs_hold,
    output reg pin_float_test_mode,
    output reg [1:0] power_state
);

    // ==========================================================
    // parameters
    parameter [15:0] WAKE_MIN_CYCLES = `PMFC_WAKE_MIN;

    // ==========================================================
    // state
    localparam [1:0] ST_ACTIVE = `PMFC_ST_ACTIVE;
    localparam [1:0] ST_IDLE = `PMFC_ST_IDLE;
    localparam [1:0] ST_PDOWN = `PMFC_ST_PDOWN;
    localparam [1:0] ST_WAKE = `PMFC_ST_WAKE;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg float_mode_ff;
    reg nxt_float_mode;
    reg [15:0] ad_last_ff;
    reg [15:0] nxt_ad_last;
    reg in_reset;
    wire wake_start;
    wire wake_done;
    wire exec_en;
    wire periph_en;
    reg [2:0] pin_cond;
    reg [2:0] ad_pin_kind;

    // core reset seen by the manager: block reset or board reset input
    always @* begin
        in_reset = !nrst || !reset_in_n;
    end

    // ==========================================================
    // power state machine
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_ACTIVE: begin
                if (mode_req_valid && mode_req == `PMFC_REQ_IDLE) begin
                    nxt_state = ST_IDLE;
                end else if (mode_req_valid &&
                             mode_req == `PMFC_REQ_PDOWN) begin
                    nxt_state = ST_PDOWN;
                end
            end
            ST_IDLE: begin
                if (wake_event) begin
                    nxt_state = ST_ACTIVE;
                end
            end
            ST_PDOWN: begin
                if (wake_event) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_done) begin
                    nxt_state = ST_ACTIVE;
                end
            end
            default: begin
                nxt_state = ST_ACTIVE;
            end
        endcase
    end

    // board reset returns the manager to active; contents otherwise kept
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_ACTIVE;
        end else if (!reset_in_n) begin
            state_ff <= ST_ACTIVE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wake_start = (state_ff == ST_PDOWN) && wake_event;

    // ==========================================================
    // pin float test mode latch
    // strap sampled on every edge while reset input is low, so the value
    // taken is the one present at the release
    always @* begin
        nxt_float_mode = float_mode_ff;
        if (!reset_in_n) begin
            nxt_float_mode = !float_test_strap_in;
        end
    end

    // asynchronous block reset clears it; strap is caught by the clock
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            float_mode_ff <= 1'b0;
        end else begin
            float_mode_ff <= nxt_float_mode;
        end
    end

    // ==========================================================
    // special pin conditions
    // reset beats bus hold, and bus hold beats the powerdown retain
    localparam [2:0] COND_RUN = 3'h0;
    localparam [2:0] COND_HOLD = 3'h1;
    localparam [2:0] COND_RESET = 3'h2;
    localparam [2:0] COND_IDLE = 3'h3;
    localparam [2:0] COND_PDOWN = 3'h4;

    // address data pin kind in each condition
    localparam [2:0] AD_KIND_RUN = `PMFC_PIN_ACTIVE;
    localparam [2:0] AD_KIND_HOLD = `PMFC_PIN_FLOAT;
    localparam [2:0] AD_KIND_RESET = `PMFC_PIN_FLOAT;
    localparam [2:0] AD_KIND_IDLE = `PMFC_PIN_ACTIVE;
    localparam [2:0] AD_KIND_PDOWN = `PMFC_PIN_RETAIN;

    // the wake wait counts as powerdown so the bus stays frozen until
    // the oscillator is trusted again
    always @* begin
        if (!reset_in_n) begin
            pin_cond = COND_RESET;
        end else if (bus_hold_ack) begin
            pin_cond = COND_HOLD;
        end else if (nxt_state == ST_PDOWN || state_ff == ST_PDOWN ||
                     state_ff == ST_WAKE) begin
            pin_cond = COND_PDOWN;
        end else if (state_ff == ST_IDLE) begin
            pin_cond = COND_IDLE;
        end else begin
            pin_cond = COND_RUN;
        end
    end

    always @* begin
        case (pin_cond)
            COND_HOLD: begin
                ad_pin_kind = AD_KIND_HOLD;
            end
            COND_RESET: begin
                ad_pin_kind = AD_KIND_RESET;
            end
            COND_IDLE: begin
                ad_pin_kind = AD_KIND_IDLE;
            end
            COND_PDOWN: begin
                ad_pin_kind = AD_KIND_PDOWN;
            end
            default: begin
                ad_pin_kind = AD_KIND_RUN;
            end
        endcase
    end

    // ==========================================================
    // last driven bus value, frozen outside active and idle operation
    // captured only while the pins really follow the bus unit, so the
    // entry edge into powerdown cannot slip a newer value in
    always @* begin
        nxt_ad_last = ad_last_ff;
        if (ad_pin_kind == `PMFC_PIN_ACTIVE && bus_ad_drive) begin
            nxt_ad_last = bus_ad_value;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ad_last_ff <= `PMFC_AD_RST;
        end else begin
            ad_last_ff <= nxt_ad_last;
        end
    end

    assign bus_ad_sample = addr_data_bus_in;

    // ==========================================================
    // clock gating
    // regs only lose clocks, never contents, so state survives powerdown
    assign exec_en = (state_ff == ST_ACTIVE) && !in_reset;
    assign periph_en = (state_ff == ST_ACTIVE) ||
                       (state_ff == ST_IDLE);

    pmfc_clk_gate u_exec_gate (
        .clk_in(ref_clk),
        .nrst(nrst),
        .enable(exec_en),
        .clk_out(exec_clk)
    );

    pmfc_clk_gate u_bus_gate (
        .clk_in(ref_clk),
        .nrst(nrst),
        .enable(exec_en),
        .clk_out(bus_clk)
    );

    pmfc_clk_gate u_periph_gate (
        .clk_in(ref_clk),
        .nrst(nrst),
        .enable(periph_en),
        .clk_out(periph_clk)
    );

    pmfc_wake_timer u_wake (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(wake_start),
        .timer_pin_done(wake_delay_timer_pin_in),
        .min_cycles(WAKE_MIN_CYCLES),
        .done(wake_done)
    );

    // strap pull is weak, only during reset
    assign float_test_strap_pullup = in_reset;

    // ==========================================================
    // output pins, registered
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            addr_data_bus_out <= `PMFC_AD_RST;
            addr_data_bus_oe <= 16'h0000;
            reset_out <= 1'b1;
            reset_out_oe <= 1'b1;
            osc_enable <= 1'b1;
            regs_hold <= 1'b0;
            pin_float_test_mode <= 1'b0;
            power_state <= ST_ACTIVE;
            float_test_strap_out <= 1'b0;
            float_test_strap_oe <= 1'b0;
            wake_delay_timer_pin_out <= 1'b0;
            wake_delay_timer_pin_oe <= 1'b0;
        end else begin
            pin_float_test_mode <= nxt_float_mode;
            power_state <= (!reset_in_n) ? ST_ACTIVE : nxt_state;
            reset_out <= !reset_in_n;
            reset_out_oe <= 1'b1;
            osc_enable <= !(nxt_state == ST_PDOWN && reset_in_n);
            regs_hold <= (nxt_state == ST_PDOWN) && reset_in_n;
            float_test_strap_out <= 1'b0;
            float_test_strap_oe <= 1'b0;
            // timer pin: float in reset, driven high in powerdown
            wake_delay_timer_pin_out <= 1'b1;
            wake_delay_timer_pin_oe <= reset_in_n &&
                                       (nxt_state == ST_PDOWN);
            case (ad_pin_kind)
                `PMFC_PIN_FLOAT: begin
                    addr_data_bus_oe <= 16'h0000;
                    addr_data_bus_out <= addr_data_bus_out;
                end
                `PMFC_PIN_RETAIN: begin
                    addr_data_bus_oe <= addr_data_bus_oe;
                    addr_data_bus_out <= ad_last_ff;
                end
                default: begin
                    addr_data_bus_oe <= {16{bus_ad_drive}};
                    addr_data_bus_out <= bus_ad_value;
                end
            endcase
            // float test mode overrides every pin enable
            if (nxt_float_mode) begin
                addr_data_bus_oe <= 16'h0000;
                reset_out_oe <= 1'b0;
                wake_delay_timer_pin_oe <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// file: hdl/pmfc_defines.vh
/*
 * power mode and pin float control: shared constants.
 * assumes inclusion by bare name from hdl/ design files.
 */
`ifndef PMFC_DEFINES_VH
`define PMFC_DEFINES_VH

// ==========================================================
// power states
`define PMFC_ST_ACTIVE 2'h0
`define PMFC_ST_IDLE 2'h1
`define PMFC_ST_PDOWN 2'h2
`define PMFC_ST_WAKE 2'h3

// ==========================================================
// mode request encodings
`define PMFC_REQ_ACTIVE 2'h0
`define PMFC_REQ_IDLE 2'h1
`define PMFC_REQ_PDOWN 2'h2

// ==========================================================
// pin state kinds per special condition
`define PMFC_PIN_HIGH 3'h0
`define PMFC_PIN_LOW 3'h1
`define PMFC_PIN_FLOAT 3'h2
`define PMFC_PIN_ACTIVE 3'h3
`define PMFC_PIN_RETAIN 3'h4

// ==========================================================
// widths and reset values
`define PMFC_AD_W 16
`define PMFC_AD_RST 16'h0000
`define PMFC_WAKE_CNT_W 16
`define PMFC_WAKE_MIN 16'h0001

`endif

// file: hdl/pmfc_clk_gate.v
/*
 * glitch free clock gate holding its output low while disabled.
 * assumes clk_in is the core clock and enable is synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none

module pmfc_clk_gate (
    input wire clk_in,
    input wire nrst,
    input wire enable,
    output wire clk_out
);

    // ==========================================================
    // latch style gate built from a falling edge flop
    reg en_ff;

    // enable changes only while clk_in is low so the output never glitches
    always @(negedge clk_in or negedge nrst) begin
        if (!nrst) begin
            en_ff <= 1'b0;
        end else begin
            en_ff <= enable;
        end
    end

    // stopped clock rests at logic zero
    assign clk_out = clk_in & en_ff;

endmodule

`default_nettype wire

// file: hdl/pmfc_wake_timer.v
/*
 * wake delay counter started on leaving powerdown.
 * assumes the wake delay timer pin level means the external capacitor
 * has charged; the count sets a minimum delay on top of it.
 */
`timescale 1ns/1ps
`default_nettype none

module pmfc_wake_timer (
    input wire ref_clk,
    input wire nrst,
    input wire start,
    input wire timer_pin_done,
    input wire [15:0] min_cycles,
    output wire done
);

    // ==========================================================
    // counter
    reg [15:0] cnt_ff;
    reg run_ff;
    reg [15:0] nxt_cnt;
    reg nxt_run;

    always @* begin
        nxt_cnt = cnt_ff;
        nxt_run = run_ff;
        if (start) begin
            nxt_cnt = 16'h0000;
            nxt_run = 1'b1;
        end else if (run_ff && cnt_ff != min_cycles) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 16'h0000;
            run_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
        end
    end

    // both the minimum count and the external pin must agree
    assign done = run_ff && !start && (cnt_ff == min_cycles) &&
                  timer_pin_done;

endmodule

`default_nettype wire

// file: dv/pmfc_power_properties.sv
/* concurrent checks on the power control ports.
   assumes bind to pmfc_power_ctrl; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "pmfc_defines.vh"
module pmfc_power_props (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reset_in_n,
    input wire logic float_test_strap_in,
    input wire logic float_test_strap_oe,
    input wire logic float_test_strap_pullup,
    input wire logic wake_delay_timer_pin_oe,
    input wire logic bus_hold_ack,
    input wire logic [15:0] addr_data_bus_out,
    input wire logic [15:0] addr_data_bus_oe,
    input wire logic reset_out,
    input wire logic reset_out_oe,
    input wire logic osc_enable,
    input wire logic exec_clk,
    input wire logic bus_clk,
    input wire logic periph_clk,
    input wire logic regs_hold,
    input wire logic pin_float_test_mode,
    input wire logic [1:0] power_state
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // pins
    a_rst_out_follow: assert property (!reset_in_n |=> reset_out)
        else $error("reset output dropped during board reset");
    a_ad_float_rst: assert property (!reset_in_n |=> !addr_data_bus_oe)
        else $error("bus driven during board reset");
    a_ad_float_hold: assert property (bus_hold_ack |=> !addr_data_bus_oe)
        else $error("bus driven after hold acknowledge");
    a_float_all_off: assert property (pin_float_test_mode
        && $past(pin_float_test_mode) |-> !addr_data_bus_oe && !reset_out_oe
        && !wake_delay_timer_pin_oe && !float_test_strap_oe)
        else $error("pin driven in float test mode");
    a_strap_sample: assert property (!reset_in_n |=>
        pin_float_test_mode == !$past(float_test_strap_in))
        else $error("float mode not taken from strap");
    a_mode_latched: assert property (reset_in_n && $past(reset_in_n)
        |-> $stable(pin_float_test_mode))
        else $error("float mode changed outside reset");
    a_strap_pull: assert property (!reset_in_n |-> float_test_strap_pullup)
        else $error("strap not pulled during reset");
    // ==========================================================
    // power states
    a_pdown_osc_off: assert property (power_state == `PMFC_ST_PDOWN
        |-> !osc_enable && regs_hold)
        else $error("oscillator on or registers free in powerdown");
    a_ad_retain: assert property (power_state == `PMFC_ST_PDOWN
        && $past(power_state) == `PMFC_ST_PDOWN |-> $stable(addr_data_bus_out))
        else $error("bus value changed in powerdown");
    // gated clocks are sampled at the fall, just before a high phase ends
    a_idle_clocks: assert property (@(negedge ref_clk) disable iff (!nrst)
        power_state == `PMFC_ST_IDLE && $past(power_state) == `PMFC_ST_IDLE
        |-> !exec_clk && !bus_clk && periph_clk)
        else $error("wrong clocks in idle");
    a_pdown_clocks: assert property (@(negedge ref_clk) disable iff (!nrst)
        power_state == `PMFC_ST_PDOWN && $past(power_state) == `PMFC_ST_PDOWN
        |-> !exec_clk && !bus_clk && !periph_clk)
        else $error("clock running in powerdown");
    a_active_clocks: assert property (@(negedge ref_clk) disable iff (!nrst)
        power_state == `PMFC_ST_ACTIVE && $past(power_state) == `PMFC_ST_ACTIVE
        && !reset_out && !$past(reset_out) |-> exec_clk && bus_clk && periph_clk)
        else $error("clock stopped in active");
    c_idle: cover property (power_state == `PMFC_ST_IDLE);
    c_pdown: cover property (power_state == `PMFC_ST_PDOWN);
    c_float: cover property (pin_float_test_mode && reset_in_n);
endmodule
bind pmfc_power_ctrl pmfc_power_props pmfc_power_props_inst (.*);
`default_nettype wire

// file: dv/pmfc_board_model.sv
/* board reset logic and strap driver.
   assumes the bench requests reset and strap level; reset is
   launched on the rising edge so the design sees it a cycle later. */
`timescale 1ns/1ps
`default_nettype none
module pmfc_board_model (
    input wire logic ref_clk,
    input wire logic rst_req,
    input wire logic strap_low,
    input wire logic pull_on,
    output logic reset_in_n,
    output logic strap_level
);
    logic last_ff = 1'b1;
    initial reset_in_n = 1'b0;
    always @(posedge ref_clk) begin
        reset_in_n <= !rst_req;
        last_ff <= strap_level;
    end
    // undriven and unpulled strap toggles so no stale level is seen
    assign strap_level = strap_low ? 1'b0 : (pull_on ? 1'b1 : ~last_ff);
endmodule
`default_nettype wire

// file: dv/test_power_mode_and_pin_float_ctrl.sv
/* self-checking bench for the power mode and pin float control.
   assumes a 25 MHz core clock; the board model drives reset and strap. */
`timescale 1ns/1ps
`default_nettype none
`include "pmfc_defines.vh"
module test_power_mode_and_pin_float_ctrl;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic rst_req = 1'b1;
    logic strap_low = 1'b0;
    logic timer_ready = 1'b0;
    logic [1:0] mode_req = 2'h0;
    logic mode_req_valid = 1'b0;
    logic wake_event = 1'b0;
    logic bus_hold_ack = 1'b0;
    logic bus_ad_drive = 1'b0;
    logic [15:0] bus_ad_value = 16'h0000;
    logic [15:0] clk_seen;
    wire reset_in_n, strap_level, strap_pu, t_out, t_oe, t_pin;
    wire rout, rout_oe, osc_en, e_clk, b_clk, p_clk, hold, fmode;
    wire s_out, s_oe;
    wire [15:0] ad_out, ad_oe, ad_pin, ad_smp;
    wire [1:0] pstate;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    assign t_pin = t_oe ? t_out : timer_ready;
    // released bus lines show a pattern rather than a stale value
    assign ad_pin = (ad_out & ad_oe) | (~ad_oe & 16'h3c3c);
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    pmfc_power_ctrl #(.WAKE_MIN_CYCLES(16'h0004)) pmfc_power_ctrl_inst (
        .ref_clk(ref_clk), .nrst(nrst), .reset_in_n(reset_in_n),
        .mode_req(mode_req), .mode_req_valid(mode_req_valid),
        .wake_event(wake_event), .float_test_strap_in(strap_level),
        .float_test_strap_out(s_out), .float_test_strap_oe(s_oe),
        .float_test_strap_pullup(strap_pu), .wake_delay_timer_pin_in(t_pin),
        .wake_delay_timer_pin_out(t_out), .wake_delay_timer_pin_oe(t_oe),
        .bus_hold_ack(bus_hold_ack), .bus_ad_value(bus_ad_value),
        .bus_ad_drive(bus_ad_drive), .addr_data_bus_in(ad_pin),
        .addr_data_bus_out(ad_out), .addr_data_bus_oe(ad_oe),
        .bus_ad_sample(ad_smp), .reset_out(rout), .reset_out_oe(rout_oe),
        .osc_enable(osc_en), .exec_clk(e_clk), .bus_clk(b_clk),
        .periph_clk(p_clk), .regs_hold(hold), .pin_float_test_mode(fmode),
        .power_state(pstate));
    pmfc_board_model pmfc_board_model_inst (.ref_clk(ref_clk),
        .rst_req(rst_req), .strap_low(strap_low), .pull_on(strap_pu),
        .reset_in_n(reset_in_n), .strap_level(strap_level));
    // ==========================================================
    // helpers
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task grab_clks;
        @(posedge ref_clk);
        #10;
        clk_seen = {13'h0000, e_clk, b_clk, p_clk};
        @(negedge ref_clk);
    endtask
    task request(input logic [1:0] m);
        mode_req = m;
        mode_req_valid = 1'b1;
        step(1);
        mode_req_valid = 1'b0;
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            finish_test;
        end
    end
    // ==========================================================
    // scenarios
    task board_reset(input logic lo);
        strap_low = lo;
        rst_req = 1'b1;
        step(4);
        chk(rout, 16'h0001);
        chk(ad_oe, 16'h0000);
        chk(strap_pu, 16'h0001);
        rst_req = 1'b0;
        step(2);
        strap_low = 1'b0; // strap held until reset has gone
        step(4);
        chk(rout, 16'h0000);
        chk(fmode, lo);
        $display("board reset strap=%0d done", lo);
    endtask
    task t_float;
        board_reset(1'b1);
        chk(ad_oe, 16'h0000);
        chk({rout_oe, t_oe}, 16'h0000);
        chk({s_out, s_oe}, 16'h0000);
        step(6);
        chk(fmode, 16'h0001);
        board_reset(1'b0);
        $display("float test done");
    endtask
    task t_idle;
        request(`PMFC_REQ_ACTIVE);
        chk(pstate, `PMFC_ST_ACTIVE);
        step(1);
        request(`PMFC_REQ_IDLE);
        chk(pstate, `PMFC_ST_IDLE);
        step(2);
        grab_clks;
        chk(clk_seen, 16'h0001);
        request(`PMFC_REQ_PDOWN);
        chk(pstate, `PMFC_ST_IDLE);
        wake_event = 1'b1;
        step(1);
        wake_event = 1'b0;
        chk(pstate, `PMFC_ST_ACTIVE);
        step(2);
        grab_clks;
        chk(clk_seen, 16'h0007);
        $display("idle test done");
    endtask
    task t_pdown;
        int k;
        bus_ad_value = 16'h5a3c;
        bus_ad_drive = 1'b1;
        step(2);
        chk(ad_out, 16'h5a3c);
        request(`PMFC_REQ_PDOWN);
        chk(pstate, `PMFC_ST_PDOWN);
        chk({osc_en, hold}, 16'h0001);
        chk({t_oe, t_out}, 16'h0003);
        bus_ad_value = 16'hc3a5;
        step(3);
        chk(ad_out, 16'h5a3c);
        chk(ad_oe, 16'hffff);
        grab_clks;
        chk(clk_seen, 16'h0000);
        wake_event = 1'b1;
        step(1);
        wake_event = 1'b0;
        step(20);
        chk(pstate, `PMFC_ST_WAKE);
        timer_ready = 1'b1;
        k = 0;
        while (pstate !== `PMFC_ST_ACTIVE && k < 10) begin
            step(1);
            k++;
        end
        chk(pstate, `PMFC_ST_ACTIVE);
        chk({osc_en, hold}, 16'h0002);
        // timer pin already ready: only the minimum count holds the wait
        request(`PMFC_REQ_PDOWN);
        wake_event = 1'b1;
        step(1);
        wake_event = 1'b0;
        step(4);
        chk(pstate, `PMFC_ST_WAKE);
        step(1);
        chk(pstate, `PMFC_ST_ACTIVE);
        timer_ready = 1'b0;
        $display("powerdown test done");
    endtask
    task t_hold;
        bus_hold_ack = 1'b1;
        step(1);
        chk(ad_oe, 16'h0000);
        chk(ad_smp, 16'h3c3c);
        bus_hold_ack = 1'b0;
        step(2);
        chk(ad_oe, 16'hffff);
        chk(ad_smp, 16'hc3a5);
        $display("hold test done");
    endtask
    initial begin
        step(10);
        nrst = 1'b1;
        step(1);
        t_float;
        t_idle;
        t_pdown;
        t_hold;
        finish_test;
    end
endmodule
`default_nettype wire
